// File: src/tcp_socket_pkg.sv
// Shared constants and types for the TCP socket engine.
package tcp_socket_pkg;

  // Socket count and socket index width.
  localparam int SOCKETS = 8;
  localparam int SOCK_W = 3;

  // Per-socket buffer size and offset mask; pointers are free-running 16-bit counters.
  localparam logic [15:0] BUF_SIZE = 16'h0800;
  localparam logic [15:0] BUF_MASK = 16'h07FF;

  // Largest data segment carried in one transmit descriptor.
  localparam logic [15:0] SEG_MSS = 16'h05B4;

  // Protocol mode code that selects TCP.
  localparam logic [3:0] MODE_TCP = 4'h1;

  // Retry interval unit: 100 us per step at an 8 ns clock.
  localparam int CLK_PERIOD_NS = 8;
  localparam int RETRY_UNIT_NS = 100000;
  localparam int RETRY_UNIT_CYCLES = (RETRY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Event flag bit positions.
  localparam int FLAG_W = 5;
  localparam int FLAG_CONNECTED = 0;
  localparam int FLAG_DISCONNECT = 1;
  localparam int FLAG_RECEIVED = 2;
  localparam int FLAG_TIMEOUT = 3;
  localparam int FLAG_SEND_DONE = 4;

  // Depth of the transmit descriptor queue.
  localparam int FIFO_DEPTH = 8;

  // Connection state of one socket.
  typedef enum logic [2:0] {
    state_shut, state_initialized, state_listening, state_syn_received,
    state_connected, state_peer_closing, state_disconnecting, state_syn_sent
  } socket_state_type;

  // Host commands; cmd_none means the command slot is empty.
  typedef enum logic [2:0] {
    cmd_none, cmd_open, cmd_listen, cmd_connect,
    cmd_disconnect, cmd_close, cmd_send, cmd_receive_done
  } socket_command_type;

  // Segment arrivals reported by the receive path.
  typedef enum logic [2:0] {
    net_syn, net_syn_ack, net_ack, net_data, net_fin
  } net_event_type;

  // Segment kinds queued for transmission.
  typedef enum logic [2:0] {
    seg_syn, seg_syn_ack, seg_ack, seg_data, seg_fin
  } seg_kind_type;

  // Transmit descriptor handed to the framing logic.
  typedef struct packed {
    logic [SOCK_W-1:0] sock;
    seg_kind_type kind;
    logic [15:0] port;
    logic [15:0] offset;
    logic [15:0] len;
  } seg_type;

endpackage

// File: src/seg_fifo_if.sv
// Valid/ready carrier between the socket engine and its descriptor queue.
`timescale 1ns/1ns
interface seg_fifo_if #(parameter int WIDTH = 8);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;

  // The queue itself.
  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
  // The logic that fills and drains the queue.
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface

// File: src/seg_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module seg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  seg_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words.
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d;       // Write index.
  logic [AW-1:0] rd_q, rd_d;       // Read index.
  logic [AW:0] cnt_q, cnt_d;       // Words held.
  logic push;
  logic pop;

  // Full and empty come straight from the count, so the filler really stalls.
  assign q.in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign q.out_valid = (cnt_q != '0);
  assign q.out_data = mem_q[rd_q];

  // Next-state of indices, count and storage.
  always_comb begin
    push = q.in_valid && q.in_ready;
    pop = q.out_valid && q.out_ready;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = q.in_data;
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Registers; the storage needs no reset since count guards it.
  always_ff @(posedge sys_clk_i) begin
    mem_q <= mem_d;
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// File: src/tcp_socket_engine.sv
// Eight-socket TCP connection engine: commands, states, flags, pointers, retries.
`timescale 1ns/1ns
// Overview of operation
// - Eight independent sockets with own state
// - Open with TCP mode gives initialized state
// - Listen on initialized socket gives listening
// - Incoming SYN: syn-received, reply, then connected
// - Connection sets connected flag and state
// - Host clears flags by writing ones
// - Receive flag set per segment, merges
// - Received size counts unread bytes
// - Oversize segment refused, connection paused
// - Receive-done releases space up to pointer
// - Sends split into maximum-size segments
// - Send transmits between old and new pointer
// - Peer FIN: disconnect flag, peer-closing state
// - Disconnect exchange ends shut with flag
// - Retries exhausted: timeout flag, shut state
// - Interrupt only when socket and global enabled
// - Client opens actively, server passively
// - Connect command sends SYN to server
// - Close shuts socket at once
// - Retry interval counts 100 us steps
module tcp_socket_engine
  import tcp_socket_pkg::*;
#(
  parameter int TICK_CYCLES = RETRY_UNIT_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [SOCK_W-1:0] host_sock_i,
  input wire logic host_cmd_we_i,
  input wire socket_command_type host_cmd_i,
  input wire logic [15:0] host_ptr_i,
  input wire logic [3:0] host_mode_i,
  input wire logic [15:0] host_port_i,
  input wire logic host_flag_clr_we_i,
  input wire logic [FLAG_W-1:0] host_flag_clr_i,
  input wire logic [SOCKETS-1:0][FLAG_W-1:0] socket_event_mask_i,
  input wire logic [SOCKETS-1:0] global_event_mask_i,
  input wire logic [15:0] retry_interval_i,
  input wire logic [7:0] retry_count_i,
  input wire logic net_valid_i,
  input wire logic [SOCK_W-1:0] net_sock_i,
  input wire net_event_type net_event_i,
  input wire logic [15:0] net_len_i,
  input wire logic seg_ready_i,
  output socket_state_type socket_state_o,
  output logic [FLAG_W-1:0] socket_event_flags_o,
  output socket_command_type socket_command_o,
  output logic [15:0] rx_received_size_o,
  output logic [15:0] tx_free_size_o,
  output logic net_accept_o,
  output logic net_pause_o,
  output logic seg_valid_o,
  output seg_type seg_o,
  output logic irq_o
);

  // Bytes between two free-running pointers.
  function automatic logic [15:0] ptr_span(input logic [15:0] hi, input logic [15:0] lo);
    ptr_span = hi - lo;
  endfunction

  // Buffer offset from a free-running pointer.
  function automatic logic [15:0] buf_offset(input logic [15:0] ptr);
    buf_offset = ptr & BUF_MASK;
  endfunction

  // Per-socket state, one entry per socket.
  socket_state_type state_q [SOCKETS], state_d [SOCKETS];
  socket_command_type cmd_q [SOCKETS], cmd_d [SOCKETS];  // Pending command slot.
  logic [15:0] cptr_q [SOCKETS], cptr_d [SOCKETS];       // Pointer written with the command.
  logic [3:0] mode_q [SOCKETS], mode_d [SOCKETS];        // Protocol mode.
  logic [15:0] port_q [SOCKETS], port_d [SOCKETS];       // Source port.
  logic [FLAG_W-1:0] flags_q [SOCKETS], flags_d [SOCKETS];
  logic [15:0] rx_wr_q [SOCKETS], rx_wr_d [SOCKETS];     // Receive fill pointer.
  logic [15:0] rx_rd_q [SOCKETS], rx_rd_d [SOCKETS];     // Receive release pointer.
  logic [15:0] tx_wr_q [SOCKETS], tx_wr_d [SOCKETS];     // End of data to send.
  logic [15:0] tx_sent_q [SOCKETS], tx_sent_d [SOCKETS]; // Next byte to segment.
  logic [15:0] tx_ack_q [SOCKETS], tx_ack_d [SOCKETS];   // Oldest unacknowledged byte.
  logic pend_q [SOCKETS], pend_d [SOCKETS];              // Segment waiting for the queue.
  seg_kind_type pkind_q [SOCKETS], pkind_d [SOCKETS];    // Kind of that segment.
  logic wait_q [SOCKETS], wait_d [SOCKETS];              // Awaiting acknowledgement.
  logic [15:0] tmr_q [SOCKETS], tmr_d [SOCKETS];         // Interval steps elapsed.
  logic [7:0] retry_q [SOCKETS], retry_d [SOCKETS];      // Retransmissions done.

  logic [15:0] tick_cnt_q, tick_cnt_d;  // Prescaler for the 100 us step.
  logic tick_q, tick_d;
  logic net_accept_d;
  logic net_pause_d;
  logic seg_valid_d;
  seg_type seg_d;
  logic irq_d;
  seg_type push_seg;
  logic found;
  int sel;
  logic [15:0] rem;
  logic [15:0] step;

  seg_fifo_if #(.WIDTH($bits(seg_type))) fq ();

  // Descriptor queue; a stalled drain fills it and stops the pending pushes.
  seg_fifo #(.WIDTH($bits(seg_type)), .DEPTH(FIFO_DEPTH)) u_queue (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .q(fq.store)
  );

  assign fq.in_data = push_seg;
  assign fq.in_valid = found;
  assign fq.out_ready = !seg_valid_o || seg_ready_i;

  // Next values of the whole engine.
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    cptr_d = cptr_q;
    mode_d = mode_q;
    port_d = port_q;
    rx_wr_d = rx_wr_q;
    rx_rd_d = rx_rd_q;
    tx_wr_d = tx_wr_q;
    tx_sent_d = tx_sent_q;
    tx_ack_d = tx_ack_q;
    pend_d = pend_q;
    pkind_d = pkind_q;
    wait_d = wait_q;
    tmr_d = tmr_q;
    retry_d = retry_q;
    net_accept_d = 1'b0;
    net_pause_d = 1'b0;
    push_seg = '0;
    found = 1'b0;
    sel = 0;
    rem = '0;
    step = '0;
    // One 100 us step per prescaler wrap.
    tick_d = (tick_cnt_q == 16'(TICK_CYCLES - 1));
    tick_cnt_d = tick_d ? '0 : tick_cnt_q + 16'h0001;

    // Lowest-numbered pending socket wins the queue slot this cycle.
    for (int s = SOCKETS - 1; s >= 0; s--) begin
      if (pend_q[s]) begin
        found = 1'b1;
        sel = s;
      end
    end
    if (found) begin
      push_seg.sock = SOCK_W'(sel);
      push_seg.kind = pkind_q[sel];
      push_seg.port = port_q[sel];
      if (pkind_q[sel] == seg_data) begin
        // Data beyond the segment limit stays pending for further segments.
        rem = ptr_span(tx_wr_q[sel], tx_sent_q[sel]);
        step = (rem > SEG_MSS) ? SEG_MSS : rem;
        push_seg.offset = buf_offset(tx_sent_q[sel]);
        push_seg.len = step;
      end
    end
    found = found && fq.in_ready;
    if (found) begin
      tx_sent_d[sel] = tx_sent_q[sel] + step;
      pend_d[sel] = (pkind_q[sel] == seg_data) && (rem != step);
      wait_d[sel] = (pkind_q[sel] != seg_ack);
      tmr_d[sel] = '0;
    end

    for (int s = 0; s < SOCKETS; s++) begin
      // Host clears first, hardware sets afterwards, so a same-cycle event survives.
      flags_d[s] = flags_q[s];
      if (host_flag_clr_we_i && host_sock_i == SOCK_W'(s)) begin
        flags_d[s] = flags_q[s] & ~host_flag_clr_i;
      end

      // Stored command is acted on and its slot emptied.
      cmd_d[s] = cmd_none;
      case (cmd_q[s])
        cmd_open: begin
          if (mode_q[s] == MODE_TCP) begin
            state_d[s] = state_initialized;
            rx_wr_d[s] = '0;
            rx_rd_d[s] = '0;
            tx_wr_d[s] = '0;
            tx_sent_d[s] = '0;
            tx_ack_d[s] = '0;
          end
        end
        cmd_listen: begin
          if (state_q[s] == state_initialized) begin
            state_d[s] = state_listening;
          end
        end
        cmd_connect: begin
          if (state_q[s] == state_initialized) begin
            state_d[s] = state_syn_sent;
            pend_d[s] = 1'b1;
            pkind_d[s] = seg_syn;
            retry_d[s] = '0;
          end
        end
        cmd_send: begin
          if (state_q[s] == state_connected || state_q[s] == state_peer_closing) begin
            tx_wr_d[s] = cptr_q[s];
            pend_d[s] = 1'b1;
            pkind_d[s] = seg_data;
            retry_d[s] = '0;
          end
        end
        cmd_receive_done: begin
          rx_rd_d[s] = cptr_q[s];
        end
        cmd_disconnect: begin
          if (state_q[s] == state_connected || state_q[s] == state_peer_closing) begin
            state_d[s] = state_disconnecting;
            pend_d[s] = 1'b1;
            pkind_d[s] = seg_fin;
            retry_d[s] = '0;
          end
        end
        cmd_close: begin
          state_d[s] = state_shut;
          pend_d[s] = 1'b0;
          wait_d[s] = 1'b0;
        end
        default: begin
        end
      endcase

      // A new host command fills the slot; mode and port are latched only with an open.
      if (host_cmd_we_i && host_sock_i == SOCK_W'(s)) begin
        cmd_d[s] = host_cmd_i;
        cptr_d[s] = host_ptr_i;
        if (host_cmd_i == cmd_open) begin
          mode_d[s] = host_mode_i;
          port_d[s] = host_port_i;
        end
      end

      // Segment arrivals from the peer.
      if (net_valid_i && net_sock_i == SOCK_W'(s)) begin
        case (net_event_i)
          net_syn: begin
            if (state_q[s] == state_listening) begin
              state_d[s] = state_syn_received;
              pend_d[s] = 1'b1;
              pkind_d[s] = seg_syn_ack;
              retry_d[s] = '0;
            end
          end
          net_syn_ack: begin
            if (state_q[s] == state_syn_sent) begin
              state_d[s] = state_connected;
              flags_d[s][FLAG_CONNECTED] = 1'b1;
              wait_d[s] = 1'b0;
              pend_d[s] = 1'b1;
              pkind_d[s] = seg_ack;
            end
          end
          net_ack: begin
            wait_d[s] = 1'b0;
            retry_d[s] = '0;
            if (state_q[s] == state_syn_received) begin
              state_d[s] = state_connected;
              flags_d[s][FLAG_CONNECTED] = 1'b1;
            end else if (state_q[s] == state_disconnecting) begin
              state_d[s] = state_shut;
              flags_d[s][FLAG_DISCONNECT] = 1'b1;
            end else begin
              tx_ack_d[s] = tx_sent_q[s];
              if (tx_sent_q[s] == tx_wr_q[s]) begin
                flags_d[s][FLAG_SEND_DONE] = 1'b1;
              end
            end
          end
          net_data: begin
            if (state_q[s] == state_connected) begin
              // A segment larger than the free space is held off.
              if (net_len_i <= BUF_SIZE - ptr_span(rx_wr_q[s], rx_rd_q[s])) begin
                rx_wr_d[s] = rx_wr_q[s] + net_len_i;
                flags_d[s][FLAG_RECEIVED] = 1'b1;
                net_accept_d = 1'b1;
              end else begin
                net_pause_d = 1'b1;
              end
            end
          end
          net_fin: begin
            if (state_q[s] == state_connected) begin
              state_d[s] = state_peer_closing;
              flags_d[s][FLAG_DISCONNECT] = 1'b1;
            end else if (state_q[s] == state_disconnecting) begin
              state_d[s] = state_shut;
              flags_d[s][FLAG_DISCONNECT] = 1'b1;
              wait_d[s] = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end

      // Retransmission timer; exhausting the retries shuts the socket.
      if (wait_q[s] && tick_q) begin
        if (tmr_q[s] + 16'h0001 >= retry_interval_i) begin
          tmr_d[s] = '0;
          if (retry_q[s] == retry_count_i) begin
            flags_d[s][FLAG_TIMEOUT] = 1'b1;
            state_d[s] = state_shut;
            wait_d[s] = 1'b0;
            pend_d[s] = 1'b0;
          end else begin
            retry_d[s] = retry_q[s] + 8'h01;
            pend_d[s] = 1'b1;
            if (pkind_q[s] == seg_data) begin
              tx_sent_d[s] = tx_ack_q[s];
            end
          end
        end else begin
          tmr_d[s] = tmr_q[s] + 16'h0001;
        end
      end
    end

    // Output stage reloads when empty or when the framer takes the descriptor.
    seg_valid_d = seg_valid_o;
    seg_d = seg_o;
    if (fq.out_ready) begin
      seg_valid_d = fq.out_valid;
      seg_d = fq.out_data;
    end

    // Interrupt needs both the socket mask and the global mask.
    irq_d = 1'b0;
    for (int s = 0; s < SOCKETS; s++) begin
      if (global_event_mask_i[s] && |(flags_q[s] & socket_event_mask_i[s])) begin
        irq_d = 1'b1;
      end
    end
  end

  // Registers only; the status view shows the socket selected by the host.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int s = 0; s < SOCKETS; s++) begin
        state_q[s] <= state_shut;
        cmd_q[s] <= cmd_none;
        cptr_q[s] <= '0;
        mode_q[s] <= '0;
        port_q[s] <= '0;
        flags_q[s] <= '0;
        rx_wr_q[s] <= '0;
        rx_rd_q[s] <= '0;
        tx_wr_q[s] <= '0;
        tx_sent_q[s] <= '0;
        tx_ack_q[s] <= '0;
        pend_q[s] <= 1'b0;
        pkind_q[s] <= seg_syn;
        wait_q[s] <= 1'b0;
        tmr_q[s] <= '0;
        retry_q[s] <= '0;
      end
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
      socket_state_o <= state_shut;
      socket_event_flags_o <= '0;
      socket_command_o <= cmd_none;
      rx_received_size_o <= '0;
      tx_free_size_o <= BUF_SIZE;
      net_accept_o <= 1'b0;
      net_pause_o <= 1'b0;
      seg_valid_o <= 1'b0;
      seg_o <= '0;
      irq_o <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      cptr_q <= cptr_d;
      mode_q <= mode_d;
      port_q <= port_d;
      flags_q <= flags_d;
      rx_wr_q <= rx_wr_d;
      rx_rd_q <= rx_rd_d;
      tx_wr_q <= tx_wr_d;
      tx_sent_q <= tx_sent_d;
      tx_ack_q <= tx_ack_d;
      pend_q <= pend_d;
      pkind_q <= pkind_d;
      wait_q <= wait_d;
      tmr_q <= tmr_d;
      retry_q <= retry_d;
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
      socket_state_o <= state_q[host_sock_i];
      socket_event_flags_o <= flags_q[host_sock_i];
      socket_command_o <= cmd_q[host_sock_i];
      rx_received_size_o <= ptr_span(rx_wr_q[host_sock_i], rx_rd_q[host_sock_i]);
      tx_free_size_o <= BUF_SIZE - ptr_span(tx_wr_q[host_sock_i], tx_ack_q[host_sock_i]);
      net_accept_o <= net_accept_d;
      net_pause_o <= net_pause_d;
      seg_valid_o <= seg_valid_d;
      seg_o <= seg_d;
      irq_o <= irq_d;
    end
  end

endmodule

// File: tb/tcp_socket_engine_properties.sv
// Port-level assertions and covers for the socket engine.
`timescale 1ns/1ns
module tcp_socket_engine_properties
  import tcp_socket_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [SOCK_W-1:0] host_sock_i,
  input wire logic host_cmd_we_i,
  input wire logic host_flag_clr_we_i,
  input wire logic [FLAG_W-1:0] host_flag_clr_i,
  input wire logic [SOCKETS-1:0] global_event_mask_i,
  input wire logic net_valid_i,
  input wire net_event_type net_event_i,
  input wire logic seg_ready_i,
  input wire socket_command_type socket_command_o,
  input wire logic [FLAG_W-1:0] socket_event_flags_o,
  input wire logic [15:0] rx_received_size_o,
  input wire logic [15:0] tx_free_size_o,
  input wire logic net_accept_o,
  input wire logic net_pause_o,
  input wire logic seg_valid_o,
  input wire seg_type seg_o,
  input wire logic irq_o
);
  // One clock domain, so one clocking and one disable serve every property.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // The slot empties one edge after the write and the status view shows that one edge later.
  cmd_clear_a: assert property (host_cmd_we_i ##1 !host_cmd_we_i |=> ##1 socket_command_o == cmd_none)
    else $error("command slot not emptied");
  accept_cause_a: assert property (net_accept_o |-> $past(net_valid_i && net_event_i == net_data))
    else $error("accept pulse without data");
  pause_cause_a: assert property (net_pause_o |-> $past(net_valid_i && net_event_i == net_data))
    else $error("pause pulse without data");
  pulse_excl_a: assert property (!(net_accept_o && net_pause_o))
    else $error("segment both taken and refused");
  seg_hold_a: assert property (seg_valid_o && !seg_ready_i |=> seg_valid_o && $stable(seg_o))
    else $error("descriptor changed while stalled");
  irq_mask_a: assert property (irq_o |-> $past(|global_event_mask_i))
    else $error("interrupt while masked");
  // The cleared flag reaches the status view two edges on, so the selection must hold meanwhile.
  flag_clr_a: assert property (host_flag_clr_we_i && host_flag_clr_i[0] && !net_valid_i
    ##1 $stable(host_sock_i) |=> !socket_event_flags_o[FLAG_CONNECTED])
    else $error("flag not cleared");
  rx_range_a: assert property (rx_received_size_o <= BUF_SIZE)
    else $error("received size beyond buffer");
  tx_range_a: assert property (tx_free_size_o <= BUF_SIZE)
    else $error("free size beyond buffer");

  // Main scenarios that the bench should reach.
  cover property (net_pause_o);
  cover property (socket_event_flags_o[FLAG_TIMEOUT]);
  cover property (seg_valid_o && seg_ready_i && seg_o.kind == seg_data);
endmodule

bind tcp_socket_engine tcp_socket_engine_properties i_chk (.sys_clk_i, .rst_i, .host_sock_i, .host_cmd_we_i,
  .host_flag_clr_we_i, .host_flag_clr_i, .global_event_mask_i, .net_valid_i, .net_event_i, .seg_ready_i,
  .socket_command_o, .socket_event_flags_o, .rx_received_size_o, .tx_free_size_o, .net_accept_o,
  .net_pause_o, .seg_valid_o, .seg_o, .irq_o);

// File: tb/net_peer_model.sv
// Far-side stand-in that takes transmit descriptors promptly or slowly.
`timescale 1ns/1ns
module net_peer_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  output logic seg_ready_o
);
  // Ready trails the stall request by one edge, as a real framer would lag.
  always_ff @(posedge sys_clk_i) begin
    seg_ready_o <= !rst_i && !stall_i;
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the socket engine.
`timescale 1ns/1ns
module tb_top;
  import tcp_socket_pkg::*;
  logic sys_clk_i = 0;
  logic rst_i = 1;
  logic [SOCK_W-1:0] host_sock_i = 0;
  logic host_cmd_we_i = 0;
  socket_command_type host_cmd_i = cmd_none;
  logic [15:0] host_ptr_i = 0;
  logic [3:0] host_mode_i = 4'h2; // Not TCP, so the first open is refused.
  logic [15:0] host_port_i = 16'h1F90;
  logic host_flag_clr_we_i = 0;
  logic [FLAG_W-1:0] host_flag_clr_i = 0;
  logic [SOCKETS-1:0][FLAG_W-1:0] socket_event_mask_i = '1;
  logic [SOCKETS-1:0] global_event_mask_i = 0;
  logic [15:0] retry_interval_i = 16'h0100; // Long, so handshakes never time out.
  logic [7:0] retry_count_i = 8'h03;
  logic net_valid_i = 0;
  logic [SOCK_W-1:0] net_sock_i = 0;
  net_event_type net_event_i = net_syn;
  logic [15:0] net_len_i = 0;
  logic seg_ready_i;
  logic stall = 1; // The peer holds off until a test takes one.
  logic [1:0] pulse_seen; // Pause and accept pulses of the last network event.
  socket_state_type socket_state_o;
  logic [FLAG_W-1:0] socket_event_flags_o;
  socket_command_type socket_command_o;
  logic [15:0] rx_received_size_o;
  logic [15:0] tx_free_size_o;
  logic net_accept_o;
  logic net_pause_o;
  logic seg_valid_o;
  seg_type seg_o;
  logic irq_o;
  int error_cnt = 0;
  int num_checks = 0;

  // A short retry step keeps the timeout test brief.
  tcp_socket_engine #(.TICK_CYCLES(4)) i_dut (.sys_clk_i, .rst_i, .host_sock_i, .host_cmd_we_i,
    .host_cmd_i, .host_ptr_i, .host_mode_i, .host_port_i, .host_flag_clr_we_i, .host_flag_clr_i,
    .socket_event_mask_i, .global_event_mask_i, .retry_interval_i, .retry_count_i, .net_valid_i,
    .net_sock_i, .net_event_i, .net_len_i, .seg_ready_i, .socket_state_o, .socket_event_flags_o,
    .socket_command_o, .rx_received_size_o, .tx_free_size_o, .net_accept_o, .net_pause_o,
    .seg_valid_o, .seg_o, .irq_o);
  net_peer_model i_peer (.sys_clk_i, .rst_i, .stall_i(stall), .seg_ready_o(seg_ready_i));

  // Free-running clock at 8 ns.
  always #4 sys_clk_i = ~sys_clk_i;

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_st(socket_state_type exp);
    chk(16'(socket_state_o), 16'(exp));
  endtask

  // Command pulse, then wait until the status view shows its result.
  task automatic issue(socket_command_type c, logic [15:0] p);
    @(posedge sys_clk_i);
    host_cmd_we_i <= 1;
    host_cmd_i <= c;
    host_ptr_i <= p;
    @(posedge sys_clk_i);
    host_cmd_we_i <= 0;
    tick(2);
    #1;
  endtask

  // One segment event; the one-cycle accept or pause pulse is caught while it stands.
  task automatic net(net_event_type e, logic [15:0] l);
    @(posedge sys_clk_i);
    net_valid_i <= 1;
    net_event_i <= e;
    net_len_i <= l;
    @(posedge sys_clk_i);
    net_valid_i <= 0;
    #1;
    pulse_seen = {net_pause_o, net_accept_o};
    tick(1);
    #1;
  endtask

  task automatic clear(logic [FLAG_W-1:0] b);
    @(posedge sys_clk_i);
    host_flag_clr_we_i <= 1;
    host_flag_clr_i <= b;
    @(posedge sys_clk_i);
    host_flag_clr_we_i <= 0;
    tick(1);
    #1;
  endtask

  // Lets the peer take exactly one descriptor.
  task automatic take;
    @(posedge sys_clk_i);
    stall <= 0;
    @(posedge sys_clk_i);
    stall <= 1;
    tick(2);
    #1;
  endtask

  // Waits for a descriptor and skips others until one of the wanted kind stands.
  task automatic seek(seg_kind_type k);
    for (int i = 0; i < 10; i++) begin
      if (seg_valid_o === 1'b1 && seg_o.kind === k) break;
      if (seg_valid_o === 1'b1) take;
      else #8;
    end
    chk(16'({seg_valid_o, seg_o.kind}), 16'({1'b1, k}));
  endtask

  task automatic t_open;
    chk_st(state_shut);
    chk(tx_free_size_o, 16'h0800);
    issue(cmd_open, 0);
    chk_st(state_shut);
    @(posedge sys_clk_i);
    host_mode_i <= MODE_TCP;
    issue(cmd_listen, 0);
    chk_st(state_shut);
    issue(cmd_open, 0);
    chk_st(state_initialized);
    issue(cmd_listen, 0);
    chk_st(state_listening);
    chk(16'(socket_command_o), 16'(cmd_none));
    $display("open test done");
  endtask

  task automatic t_conn;
    net(net_syn, 0);
    chk_st(state_syn_received);
    seek(seg_syn_ack);
    chk(seg_o.port, 16'h1F90);
    take;
    net(net_ack, 0);
    chk_st(state_connected);
    chk(16'(socket_event_flags_o), 16'h0001);
    chk(16'(irq_o), 16'h0000);
    @(posedge sys_clk_i);
    global_event_mask_i <= 8'h01;
    tick(2);
    #1;
    chk(16'(irq_o), 16'h0001);
    clear(5'h01);
    chk(16'(socket_event_flags_o), 16'h0000);
    tick(1);
    #1;
    chk(16'(irq_o), 16'h0000);
    $display("connect test done");
  endtask

  task automatic t_rx;
    net(net_data, 16'd100);
    chk(16'(pulse_seen), 16'h0001);
    chk(rx_received_size_o, 16'd100);
    net(net_data, 16'd50);
    chk(16'(socket_event_flags_o[FLAG_RECEIVED]), 16'h0001);
    chk(rx_received_size_o, 16'd150);
    net(net_data, 16'd2000);
    chk(16'(pulse_seen), 16'h0002);
    chk(rx_received_size_o, 16'd150);
    issue(cmd_receive_done, 16'd150);
    chk(rx_received_size_o, 16'h0000);
    clear(5'h04);
    $display("receive test done");
  endtask

  task automatic t_tx;
    issue(cmd_send, 16'd2000);
    chk(tx_free_size_o, 16'd48);
    seek(seg_data);
    chk(seg_o.len, SEG_MSS);
    chk(seg_o.offset, 16'h0000);
    take;
    chk(seg_o.len, 16'd540);
    chk(seg_o.offset, SEG_MSS);
    take;
    net(net_ack, 0);
    chk(16'(socket_event_flags_o[FLAG_SEND_DONE]), 16'h0001);
    chk(tx_free_size_o, BUF_SIZE);
    clear(5'h10);
    $display("send test done");
  endtask

  task automatic t_close;
    net(net_fin, 0);
    chk_st(state_peer_closing);
    chk(16'(socket_event_flags_o), 16'h0002);
    clear(5'h02);
    issue(cmd_disconnect, 0);
    seek(seg_fin);
    take;
    net(net_ack, 0);
    chk_st(state_shut);
    chk(16'(socket_event_flags_o), 16'h0002);
    $display("close test done");
  endtask

  task automatic t_tmo;
    @(posedge sys_clk_i);
    host_sock_i <= 1;
    retry_interval_i <= 16'h0001;
    retry_count_i <= 8'h01;
    issue(cmd_open, 0);
    issue(cmd_connect, 0);
    chk_st(state_syn_sent);
    seek(seg_syn);
    chk(16'(seg_o.sock), 16'h0001);
    for (int i = 0; i < 300 && socket_event_flags_o[FLAG_TIMEOUT] !== 1'b1; i++) tick(1);
    #1;
    chk(16'(socket_event_flags_o[FLAG_TIMEOUT]), 16'h0001);
    chk_st(state_shut);
    $display("timeout test done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence: reset for 20 cycles, then the tests in order.
  initial begin
    tick(20);
    rst_i <= 0;
    tick(1);
    #1;
    t_open;
    t_conn;
    t_rx;
    t_tx;
    t_close;
    t_tmo;
    results;
  end

  // The tests need under 200 cycles; a hang past 6000 is a failure.
  initial begin
    tick(6000);
    error_cnt++;
    results;
  end
endmodule
